// ===== pkg/pfcu_defines.vh
`ifndef PFCU_DEFINES_VH
`define PFCU_DEFINES_VH
// ==================================================
// register byte offsets
`define PFCU_OFS_CTRL 8'h00
`define PFCU_OFS_CFG 8'h04
`define PFCU_OFS_ISR 8'h08
`define PFCU_OFS_IMR 8'h0C
`define PFCU_OFS_SA_LO 8'h10
`define PFCU_OFS_SA_HI 8'h14
`define PFCU_OFS_TXPFC 8'h18
`define PFCU_OFS_RXCNT 8'h1C
`define PFCU_OFS_TXCNT 8'h20
`define PFCU_OFS_STAT 8'h24
`define PFCU_OFS_TMR_BASE 3'h2
// ==================================================
// control register fields
`define PFCU_CTRL_TXEN 3
`define PFCU_CTRL_ZQ 12
`define PFCU_CTRL_PFC_RXEN 16
`define PFCU_CTRL_PFC_TX 17
// configuration register fields
`define PFCU_CFG_FD 1
`define PFCU_CFG_RETRY 12
// interrupt status / mask fields
`define PFCU_IRQ_RX_NZ 12
`define PFCU_IRQ_ZERO 13
`define PFCU_IRQ_TX 14
`define PFCU_IRQ_BITS 32'h0000_7000
// reset values
`define PFCU_RST_CTRL 32'h0000_0000
`define PFCU_RST_CFG 32'h0000_0000
`define PFCU_RST_IMR 32'h0000_0000
`define PFCU_RST_SA 32'h0000_0000
`define PFCU_RST_TXPFC 32'h0000_0000
// ==================================================
// frame constants
`define PFCU_RSV_DA 48'h0180C2000001
`define PFCU_CTL_TYPE 16'h8808
`define PFCU_OP_PFC 16'h0101
`define PFCU_OP_CLASSIC 16'h0001
`define PFCU_CLS_MIN_LEN 6'h12
`define PFCU_PFC_MIN_LEN 6'h22
`define PFCU_TX_LAST 6'h3B
// ==================================================
// timing: one pause quantum in bit times, bits carried per link clock edge
`define PFCU_QUANTUM_BITS 512
`define PFCU_BITS_PER_EDGE 8
`define PFCU_QUANTUM_EDGES (`PFCU_QUANTUM_BITS / `PFCU_BITS_PER_EDGE)
`endif

// ===== src/pfcu_pause_unit.v
// Overview of operation
// RULE1: priority pause reception only while control bit16 set
// RULE2: after first priority frame, classic pause ignored
// RULE3: valid priority frame reloads timers despite running pause
// RULE4: status bit12 nonzero quantum, bit13 zero quantum
// RULE5: full duplex loads timers; half duplex only interrupts
// RULE6: valid needs matching address, type 8808, opcode 0101
// RULE7: frames with FCS or receive error discarded
// RULE8: count each valid received pause frame
// RULE9: timers decrement every 512 bit times immediately
// RULE10: retry test bit: decrement each link clock, tx stopped
// RULE11: timer reaching zero sets status bit13
// RULE12: control bit17 sends frame if duplex, transmitter enabled
// RULE13: vector and times come from transmit pause register
// RULE14: send now if idle, else between frames
// RULE15: frame carries reserved DA, station SA, type, opcode
// RULE16: after sending set bit14, count transmitted frames
// RULE17: control bit12 sends frame with zero quantum
// RULE18: load timer only where its vector bit set
`timescale 1ns/100ps
`include "pfcu_defines.vh"
module pfcu_pause_unit (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output reg o_irq,
  input wire i_receive_clock,
  input wire i_rx_dv,
  input wire i_rx_er,
  input wire i_rx_fcs_bad,
  input wire [7:0] i_rx_data,
  input wire i_tx_busy,
  output reg o_tx_hold,
  output reg o_tx_en,
  output reg [7:0] o_tx_data,
  output reg [7:0] o_paused
);
  localparam TX_IDLE = 3'b001;
  localparam TX_WAIT = 3'b010;
  localparam TX_SEND = 3'b100;

  // ==================================================
  // helpers
  // byte i (0 first on the wire) of the reserved multicast address
  function [7:0] rsv_byte;
    input [2:0] idx;
    reg [47:0] da;
    begin
      da = `PFCU_RSV_DA;
      case (idx)
        3'd0: rsv_byte = da[47:40];
        3'd1: rsv_byte = da[39:32];
        3'd2: rsv_byte = da[31:24];
        3'd3: rsv_byte = da[23:16];
        3'd4: rsv_byte = da[15:8];
        default: rsv_byte = da[7:0];
      endcase
    end
  endfunction

  // station address byte i, first wire byte sits in the low bits
  function [7:0] sa_byte;
    input [2:0] idx;
    input [31:0] lo;
    input [15:0] hi;
    begin
      case (idx)
        3'd0: sa_byte = lo[7:0];
        3'd1: sa_byte = lo[15:8];
        3'd2: sa_byte = lo[23:16];
        3'd3: sa_byte = lo[31:24];
        3'd4: sa_byte = hi[7:0];
        default: sa_byte = hi[15:8];
      endcase
    end
  endfunction

  // ==================================================
  // register state
  reg [31:0] ctrl_reg;
  reg [31:0] cfg_reg;
  reg [31:0] isr_reg;
  reg [31:0] isr_next;
  reg [31:0] imr_reg;
  reg [31:0] sa_lo_reg;
  reg [15:0] sa_hi_reg;
  reg [31:0] txpfc_reg;
  reg [31:0] rxcnt_reg;
  reg [31:0] txcnt_reg;
  reg negotiated_reg;
  wire full_duplex = cfg_reg[`PFCU_CFG_FD];
  wire retry_test = cfg_reg[`PFCU_CFG_RETRY];
  wire pfc_rx_en = ctrl_reg[`PFCU_CTRL_PFC_RXEN];
  wire tx_enable = ctrl_reg[`PFCU_CTRL_TXEN];
  wire wr_ctrl = i_wr & (i_addr == `PFCU_OFS_CTRL);

  // ==================================================
  // link synchronisers: every pin passes two flops first
  reg rxc_s1, rxc_s2, rxc_s3;
  reg dv_s1, dv_s2, er_s1, er_s2, fcs_s1, fcs_s2, busy_s1, busy_s2;
  reg [7:0] data_s1, data_s2;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      rxc_s1 <= 1'b0;
      rxc_s2 <= 1'b0;
      rxc_s3 <= 1'b0;
      dv_s1 <= 1'b0;
      dv_s2 <= 1'b0;
      er_s1 <= 1'b0;
      er_s2 <= 1'b0;
      fcs_s1 <= 1'b0;
      fcs_s2 <= 1'b0;
      busy_s1 <= 1'b0;
      busy_s2 <= 1'b0;
      data_s1 <= 8'h00;
      data_s2 <= 8'h00;
    end else begin
      rxc_s1 <= i_receive_clock;
      rxc_s2 <= rxc_s1;
      rxc_s3 <= rxc_s2;
      dv_s1 <= i_rx_dv;
      dv_s2 <= dv_s1;
      er_s1 <= i_rx_er;
      er_s2 <= er_s1;
      fcs_s1 <= i_rx_fcs_bad;
      fcs_s2 <= fcs_s1;
      busy_s1 <= i_tx_busy;
      busy_s2 <= busy_s1;
      data_s1 <= i_rx_data;
      data_s2 <= data_s1;
    end
  end
  // the link clock is slow (125 ns), so the synced data is long settled at its edge
  wire link_edge = rxc_s2 & ~rxc_s3;

  // ==================================================
  // receive parser: compares on the fly, keeps only vector and times
  reg in_frame_reg;
  reg [5:0] rx_idx_reg;
  reg da_rsv_ok_reg, da_sa_ok_reg, type_ok_reg, op_pfc_reg, op_cls_reg, err_reg;
  reg [7:0] hi_byte_reg;
  reg [7:0] vec_reg;
  reg [15:0] cls_q_reg;
  reg [15:0] tm_buf [0:7];
  wire [15:0] rx_word = {hi_byte_reg, data_s2};
  wire [5:0] slot_off = rx_idx_reg - 6'd19;
  integer k;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      in_frame_reg <= 1'b0;
      rx_idx_reg <= 6'h00;
      da_rsv_ok_reg <= 1'b0;
      da_sa_ok_reg <= 1'b0;
      type_ok_reg <= 1'b0;
      op_pfc_reg <= 1'b0;
      op_cls_reg <= 1'b0;
      err_reg <= 1'b0;
      hi_byte_reg <= 8'h00;
      vec_reg <= 8'h00;
      cls_q_reg <= 16'h0000;
      for (k = 0; k < 8; k = k + 1)
        tm_buf[k] <= 16'h0000;
    end else if (link_edge) begin
      in_frame_reg <= dv_s2;
      if (dv_s2 & ~in_frame_reg) begin
        // new frame: address flags start from the first byte's compare and are knocked down byte by byte
        rx_idx_reg <= 6'h01;
        da_rsv_ok_reg <= (data_s2 == rsv_byte(3'd0)); // RULE6
        da_sa_ok_reg <= (data_s2 == sa_byte(3'd0, sa_lo_reg, sa_hi_reg)); // RULE6
        type_ok_reg <= 1'b0;
        op_pfc_reg <= 1'b0;
        op_cls_reg <= 1'b0;
        err_reg <= er_s2;
      end else if (dv_s2) begin
        if (rx_idx_reg != 6'h3F)
          rx_idx_reg <= rx_idx_reg + 6'h01;
        err_reg <= err_reg | er_s2; // RULE7
        hi_byte_reg <= data_s2;
        if (rx_idx_reg < 6'd6) begin
          if (data_s2 != rsv_byte(rx_idx_reg[2:0]))
            da_rsv_ok_reg <= 1'b0;
          if (data_s2 != sa_byte(rx_idx_reg[2:0], sa_lo_reg, sa_hi_reg))
            da_sa_ok_reg <= 1'b0;
        end
        if (rx_idx_reg == 6'd13)
          type_ok_reg <= (rx_word == `PFCU_CTL_TYPE); // RULE6
        if (rx_idx_reg == 6'd15) begin
          op_pfc_reg <= (rx_word == `PFCU_OP_PFC); // RULE6
          op_cls_reg <= (rx_word == `PFCU_OP_CLASSIC);
        end
        if (rx_idx_reg == 6'd17) begin
          vec_reg <= rx_word[7:0];
          cls_q_reg <= rx_word;
        end
        if ((rx_idx_reg >= 6'd19) && (rx_idx_reg <= 6'd33) && rx_idx_reg[0])
          tm_buf[slot_off[3:1]] <= rx_word;
      end
    end
  end

  // ==================================================
  // frame verdict at the falling edge of data valid
  wire frame_end = link_edge & in_frame_reg & ~dv_s2;
  wire addr_ok = da_rsv_ok_reg | da_sa_ok_reg;
  wire clean = ~err_reg & ~fcs_s2; // RULE7
  wire pfc_ok = op_pfc_reg & pfc_rx_en & (rx_idx_reg >= `PFCU_PFC_MIN_LEN); // RULE1
  wire cls_ok = op_cls_reg & ~negotiated_reg & (rx_idx_reg >= `PFCU_CLS_MIN_LEN); // RULE2
  wire rx_pfc = frame_end & addr_ok & type_ok_reg & clean & pfc_ok;
  wire rx_cls = frame_end & addr_ok & type_ok_reg & clean & cls_ok;
  wire rx_act = rx_pfc | rx_cls;

  // per-priority load enables and quantum test
  reg [7:0] load_en;
  reg rx_nonzero;
  integer m;
  always @* begin
    load_en = 8'h00;
    rx_nonzero = 1'b0;
    for (m = 0; m < 8; m = m + 1) begin
      if (rx_pfc) begin
        load_en[m] = vec_reg[m] & full_duplex; // RULE18 RULE5
        if (vec_reg[m] && (tm_buf[m] != 16'h0000))
          rx_nonzero = 1'b1;
      end else begin
        load_en[m] = rx_cls & full_duplex; // RULE5
        if (cls_q_reg != 16'h0000)
          rx_nonzero = 1'b1;
      end
    end
  end

  // ==================================================
  // pause timers
  reg [5:0] quanta_div_reg;
  reg [15:0] tmr_reg [0:7];
  reg [2:0] tx_state_reg;
  wire tx_stopped = ~busy_s2 & (tx_state_reg != TX_SEND);
  wire quanta_tick = link_edge & (quanta_div_reg == (`PFCU_QUANTUM_EDGES - 1)); // RULE9
  // the retry test mode trades real timing for a fast drain in test
  wire dec_tick = retry_test ? (link_edge & tx_stopped) : quanta_tick; // RULE10
  wire [7:0] zero_hit;
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_hit
      assign zero_hit[g] = dec_tick & ~load_en[g] & (tmr_reg[g] == 16'h0001); // RULE11
    end
  endgenerate

  integer n;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      quanta_div_reg <= 6'h00;
      for (n = 0; n < 8; n = n + 1)
        tmr_reg[n] <= 16'h0000;
    end else begin
      // restart the quantum divider on load so counting begins at once
      if (rx_act & full_duplex)
        quanta_div_reg <= 6'h00; // RULE9
      else if (quanta_tick)
        quanta_div_reg <= 6'h00;
      else if (link_edge)
        quanta_div_reg <= quanta_div_reg + 6'h01;
      for (n = 0; n < 8; n = n + 1) begin
        if (load_en[n])
          tmr_reg[n] <= rx_pfc ? tm_buf[n] : cls_q_reg; // RULE3
        else if (dec_tick && (tmr_reg[n] != 16'h0000))
          tmr_reg[n] <= tmr_reg[n] - 16'h0001;
      end
    end
  end

  // negotiation latch, dropped when priority reception is disabled
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      negotiated_reg <= 1'b0;
    else if (~pfc_rx_en)
      negotiated_reg <= 1'b0;
    else if (rx_pfc)
      negotiated_reg <= 1'b1; // RULE2
  end

  // ==================================================
  // transmit of priority pause frames
  reg [5:0] tx_idx_reg;
  reg zq_reg;
  reg tx_done;
  wire tx_req = wr_ctrl & (i_wdata[`PFCU_CTRL_PFC_TX] | i_wdata[`PFCU_CTRL_ZQ]);
  wire tx_allowed = full_duplex & tx_enable; // RULE12
  wire [15:0] tx_time = zq_reg ? 16'h0000 : txpfc_reg[31:16]; // RULE17 RULE13

  reg [7:0] tx_byte;
  wire [15:0] type_word = `PFCU_CTL_TYPE;
  wire [15:0] op_word = `PFCU_OP_PFC;
  always @* begin
    tx_byte = 8'h00;
    if (tx_idx_reg < 6'd6)
      tx_byte = rsv_byte(tx_idx_reg[2:0]); // RULE15
    else if (tx_idx_reg < 6'd12)
      tx_byte = sa_byte(tx_idx_reg[2:0] - 3'd6, sa_lo_reg, sa_hi_reg); // RULE15
    else if (tx_idx_reg == 6'd12)
      tx_byte = type_word[15:8];
    else if (tx_idx_reg == 6'd13)
      tx_byte = type_word[7:0];
    else if (tx_idx_reg == 6'd14)
      tx_byte = op_word[15:8];
    else if (tx_idx_reg == 6'd15)
      tx_byte = op_word[7:0];
    else if (tx_idx_reg == 6'd17)
      tx_byte = txpfc_reg[7:0]; // RULE13
    else if ((tx_idx_reg >= 6'd18) && (tx_idx_reg < 6'd34))
      tx_byte = tx_idx_reg[0] ? tx_time[7:0] : tx_time[15:8];
  end

  // one frame of 60 bytes, padded; the mac behind appends the FCS
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      tx_state_reg <= TX_IDLE;
      tx_idx_reg <= 6'h00;
      zq_reg <= 1'b0;
      tx_done <= 1'b0;
      o_tx_hold <= 1'b0;
      o_tx_en <= 1'b0;
      o_tx_data <= 8'h00;
    end else begin
      tx_done <= 1'b0;
      case (tx_state_reg)
        TX_IDLE: begin
          if (tx_req & tx_allowed) begin
            zq_reg <= i_wdata[`PFCU_CTRL_ZQ]; // RULE17
            o_tx_hold <= 1'b1; // RULE14
            tx_state_reg <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          // hold stops the next queued frame; we slip into the gap
          if (link_edge & ~busy_s2) begin
            tx_idx_reg <= 6'h00; // RULE14
            tx_state_reg <= TX_SEND;
          end
        end
        TX_SEND: begin
          if (link_edge) begin
            // index runs one past the last byte, so the end edge follows byte 59
            if (o_tx_en && (tx_idx_reg == (`PFCU_TX_LAST + 6'h01))) begin
              o_tx_en <= 1'b0;
              o_tx_data <= 8'h00;
              o_tx_hold <= 1'b0;
              tx_done <= 1'b1; // RULE16
              tx_state_reg <= TX_IDLE;
            end else begin
              o_tx_en <= 1'b1;
              o_tx_data <= tx_byte;
              tx_idx_reg <= tx_idx_reg + 6'h01;
            end
          end
        end
        default: begin
          tx_state_reg <= TX_IDLE;
          o_tx_en <= 1'b0;
          o_tx_hold <= 1'b0;
        end
      endcase
    end
  end

  // ==================================================
  // interrupt status: set wins over a write-one clear in the same cycle
  always @* begin
    isr_next = isr_reg;
    if (i_wr && (i_addr == `PFCU_OFS_ISR))
      isr_next = isr_next & ~i_wdata;
    if (rx_act & rx_nonzero)
      isr_next[`PFCU_IRQ_RX_NZ] = 1'b1; // RULE4
    if ((rx_act & ~rx_nonzero) | (|zero_hit))
      isr_next[`PFCU_IRQ_ZERO] = 1'b1; // RULE4 RULE11
    if (tx_done)
      isr_next[`PFCU_IRQ_TX] = 1'b1; // RULE16
    isr_next = isr_next & `PFCU_IRQ_BITS;
  end

  // ==================================================
  // register writes, counters and status outputs
  integer p;
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_reg <= `PFCU_RST_CTRL;
      cfg_reg <= `PFCU_RST_CFG;
      isr_reg <= 32'h0000_0000;
      imr_reg <= `PFCU_RST_IMR;
      sa_lo_reg <= `PFCU_RST_SA;
      sa_hi_reg <= 16'h0000;
      txpfc_reg <= `PFCU_RST_TXPFC;
      rxcnt_reg <= 32'h0000_0000;
      txcnt_reg <= 32'h0000_0000;
      o_irq <= 1'b0;
      o_paused <= 8'h00;
    end else begin
      isr_reg <= isr_next;
      o_irq <= |(isr_next & imr_reg); // RULE4
      for (p = 0; p < 8; p = p + 1)
        o_paused[p] <= (tmr_reg[p] != 16'h0000);
      if (rx_act)
        rxcnt_reg <= rxcnt_reg + 32'h0000_0001; // RULE8
      if (tx_done)
        txcnt_reg <= txcnt_reg + 32'h0000_0001; // RULE16
      if (i_wr) begin
        case (i_addr)
          // transmit request bits are self-clearing triggers
          `PFCU_OFS_CTRL: ctrl_reg <= i_wdata & 32'h0001_0008;
          `PFCU_OFS_CFG: cfg_reg <= i_wdata & 32'h0000_1002;
          `PFCU_OFS_IMR: imr_reg <= i_wdata & `PFCU_IRQ_BITS;
          `PFCU_OFS_SA_LO: sa_lo_reg <= i_wdata;
          `PFCU_OFS_SA_HI: sa_hi_reg <= i_wdata[15:0];
          `PFCU_OFS_TXPFC: txpfc_reg <= i_wdata & 32'hFFFF_00FF;
          default: ;
        endcase
      end
    end
  end

  // read data lands one cycle after the strobe; unmapped reads as zero
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0000_0000;
    end else if (i_rd) begin
      if (i_addr[7:5] == `PFCU_OFS_TMR_BASE)
        o_rdata <= {16'h0000, tmr_reg[i_addr[4:2]]};
      else begin
        case (i_addr)
          `PFCU_OFS_CTRL: o_rdata <= ctrl_reg;
          `PFCU_OFS_CFG: o_rdata <= cfg_reg;
          `PFCU_OFS_ISR: o_rdata <= isr_reg;
          `PFCU_OFS_IMR: o_rdata <= imr_reg;
          `PFCU_OFS_SA_LO: o_rdata <= sa_lo_reg;
          `PFCU_OFS_SA_HI: o_rdata <= {16'h0000, sa_hi_reg};
          `PFCU_OFS_TXPFC: o_rdata <= txpfc_reg;
          `PFCU_OFS_RXCNT: o_rdata <= rxcnt_reg;
          `PFCU_OFS_TXCNT: o_rdata <= txcnt_reg;
          `PFCU_OFS_STAT: o_rdata <= {29'h0, tx_state_reg != TX_IDLE, o_tx_en, negotiated_reg};
          default: o_rdata <= 32'h0000_0000;
        endcase
      end
    end else begin
      o_rdata <= 32'h0000_0000;
    end
  end
endmodule

// ===== tb/pfcu_checker.sv
`timescale 1ns/100ps
`include "pfcu_defines.vh"
// ==========
// port watcher for the pause unit
module pfcu_checker (
  input wire i_ref_clk,
  input wire i_rst,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire o_irq,
  input wire i_tx_busy,
  input wire o_tx_hold,
  input wire o_tx_en,
  input wire [7:0] o_tx_data,
  input wire [7:0] o_paused
);
  reg fd_reg;
  reg txen_reg;
  reg [10:0] on_reg;
  wire ctl_wr = i_wr && i_addr == `PFCU_OFS_CTRL;
  // shadow duplex and tx enable from the bus; count cycles a frame is on the wire
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fd_reg <= 1'b0;
      txen_reg <= 1'b0;
      on_reg <= 11'h000;
    end else begin
      if (i_wr && i_addr == `PFCU_OFS_CFG) fd_reg <= i_wdata[`PFCU_CFG_FD];
      if (ctl_wr) txen_reg <= i_wdata[`PFCU_CTRL_TXEN];
      on_reg <= o_tx_en ? on_reg + 11'h001 : 11'h000;
    end
  end
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  chk_tx_start: assert property (
    ctl_wr && i_wdata[`PFCU_CTRL_PFC_TX] && i_wdata[`PFCU_CTRL_TXEN] && fd_reg && txen_reg
    && !o_tx_hold |=> o_tx_hold) else $error("pause request not taken");
  chk_tx_refuse: assert property (
    ctl_wr && !o_tx_hold && (!fd_reg || !txen_reg && !i_wdata[`PFCU_CTRL_TXEN])
    |=> !o_tx_hold) else $error("pause request taken while not allowed");
  chk_tx_gap: assert property (o_tx_en |-> o_tx_hold)
    else $error("frame sent without hold");
  chk_tx_busy: assert property ($rose(o_tx_en) |-> !$past(i_tx_busy, 4))
    else $error("frame started over a busy transmitter");
  chk_tx_first: assert property ($rose(o_tx_en) |-> o_tx_data == 8'h01)
    else $error("first byte wrong");
  chk_tx_length: assert property (
    $fell(o_tx_en) |-> on_reg > 11'h3A1 && on_reg < 11'h3B2) else $error("frame length wrong");
  chk_tx_end: assert property ($fell(o_tx_en) |-> ##[0:2] !o_tx_hold)
    else $error("hold kept after frame");
  chk_half_duplex: assert property ($rose(|o_paused) |-> fd_reg)
    else $error("timer loaded in half duplex");
  chk_irq_masked: assert property (
    i_wr && i_addr == `PFCU_OFS_IMR && i_wdata == 32'h0000_0000 |-> ##2 !o_irq)
    else $error("interrupt with all masked");
endmodule

// ===== tb/pfcu_link_model.sv
`timescale 1ns/100ps
// ==========
// link partner: frame source on receive, byte sink on transmit
module pfcu_link_model (
  output reg o_receive_clock,
  output reg o_rx_dv,
  output reg o_rx_er,
  output reg o_rx_fcs_bad,
  output reg [7:0] o_rx_data,
  input wire i_tx_en,
  input wire [7:0] i_tx_data
);
  reg [7:0] fr [0:33];
  reg [7:0] tx_bytes [0:63];
  reg [143:0] h;
  reg er_q = 1'b0;
  reg fcs_q = 1'b0;
  integer tx_count = 0;
  integer len = 0;
  integer pos = 0;
  // the receive clock runs free like a phy's, so pause timers keep ticking
  initial begin
    o_receive_clock = 1'b0;
    o_rx_dv = 1'b0;
    o_rx_er = 1'b0;
    o_rx_fcs_bad = 1'b0;
    o_rx_data = 8'h00;
    forever #62.5 o_receive_clock = ~o_receive_clock;
  end
  // one byte per edge; idle data toggles so a stale byte never looks valid
  always @(posedge o_receive_clock) begin
    if (pos < len) begin
      o_rx_dv <= 1'b1;
      o_rx_data <= fr[pos];
      o_rx_er <= er_q && pos == 20;
      pos <= pos + 1;
    end else begin
      o_rx_dv <= 1'b0;
      o_rx_er <= 1'b0;
      o_rx_data <= ~o_rx_data;
      o_rx_fcs_bad <= fcs_q && len != 0;
      len <= 0;
      pos <= 0;
    end
    if (i_tx_en) begin
      tx_bytes[tx_count % 64] <= i_tx_data;
      tx_count <= tx_count + 1;
    end
  end
  // builds a control frame, big-endian fields, pause times after the vector
  task send(input [47:0] da, input [15:0] ty, input [15:0] op, input [7:0] v,
    input [15:0] t, input e, input f, input integer n);
    integer k;
    begin
      h = {da, 48'h0A0B0C0D0E0F, ty, op, 8'h00, v};
      for (k = 0; k < 34; k = k + 1) fr[k] = k < 18 ? h[143-8*k -: 8] : (k[0] ? t[7:0] : t[15:8]);
      @(negedge o_receive_clock);
      er_q = e;
      fcs_q = f;
      pos = 0;
      len = n;
      repeat (n + 3) @(posedge o_receive_clock);
    end
  endtask
endmodule

// ===== tb/testbench.sv
`timescale 1ns/100ps
`include "pfcu_defines.vh"
// ==========
// self-checking bench for the pause unit
module testbench;
  localparam [31:0] EN = 32'h0001_0008;
  localparam [31:0] FD = 32'h0000_0002;
  localparam [47:0] SA = 48'h021122334455;
  reg i_ref_clk;
  reg i_rst;
  reg [7:0] i_addr;
  reg [31:0] i_wdata;
  reg i_wr;
  reg i_rd;
  reg i_tx_busy;
  wire [31:0] o_rdata;
  wire o_irq, rck, dv, er, fb, o_tx_hold, o_tx_en;
  wire [7:0] rxd, o_tx_data, o_paused;
  integer failures = 0;
  integer comparisons = 0;
  integer cycles = 0;
  integer k, n;
  reg [7:0] v;
  reg [15:0] t;
  reg [31:0] r;
  time t0;
  pfcu_pause_unit pfcu_pause_unit_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .i_receive_clock(rck), .i_rx_dv(dv), .i_rx_er(er), .i_rx_fcs_bad(fb), .i_rx_data(rxd),
    .i_tx_busy(i_tx_busy), .o_tx_hold(o_tx_hold), .o_tx_en(o_tx_en), .o_tx_data(o_tx_data),
    .o_paused(o_paused));
  pfcu_link_model pfcu_link_model_i (.o_receive_clock(rck), .o_rx_dv(dv), .o_rx_er(er),
    .o_rx_fcs_bad(fb), .o_rx_data(rxd), .i_tx_en(o_tx_en), .i_tx_data(o_tx_data));
  // ==========
  // bus, frame and comparison helpers
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
    begin
      @(posedge i_ref_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
    end
  endtask
  // read data stands only in the cycle after the strobe, so sample mid-cycle
  task rd(input [7:0] a, input [31:0] exp);
    begin
      @(posedge i_ref_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      check(o_rdata, exp);
    end
  endtask
  task pfc(input [47:0] da, input [7:0] vv, input [15:0] tt);
    pfcu_link_model_i.send(da, `PFCU_CTL_TYPE, `PFCU_OP_PFC, vv, tt, 1'b0, 1'b0, 34);
  endtask
  function [7:0] txb(input integer i, input [15:0] tt);
    reg [127:0] hd;
    begin
      hd = {`PFCU_RSV_DA, SA, `PFCU_CTL_TYPE, `PFCU_OP_PFC};
      if (i < 16) txb = hd[127-8*i -: 8];
      else if (i == 17) txb = v;
      else if (i > 17 && i < 34) txb = i[0] ? tt[7:0] : tt[15:8];
      else txb = 8'h00;
    end
  endfunction
  task txchk(input [15:0] tt);
    begin
      repeat (2) @(posedge i_ref_clk);
      n = 0;
      while (o_tx_hold !== 1'b0 && n < 3000) begin
        @(posedge i_ref_clk);
        n = n + 1;
      end
      check(pfcu_link_model_i.tx_count, 60);
      for (k = 0; k < 60; k = k + 1) check(pfcu_link_model_i.tx_bytes[k], txb(k, tt));
    end
  endtask
  task end_of_test;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  initial begin
    i_ref_clk = 1'b0;
    forever #4 i_ref_clk = ~i_ref_clk;
  end
  // a hang counts as a mismatch and ends the run
  always @(posedge i_ref_clk) begin
    cycles = cycles + 1;
    if (cycles == 40000) begin
      failures = failures + 1;
      end_of_test;
    end
  end
  // ==========
  // main sequence
  initial begin
    i_rst = 1'b1;
    i_addr = 8'h00;
    i_wdata = 32'h0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_tx_busy = 1'b0;
    r = $urandom(32'h0000CF56);
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (k = 0; k < 4; k = k + 1) rd({k[5:0], 2'h0}, 32'h0);
    rd(8'h30, 32'h0);
    wr(`PFCU_OFS_SA_LO, 32'h33221102);
    wr(`PFCU_OFS_SA_HI, 32'h00005544);
    wr(`PFCU_OFS_CFG, FD);
    wr(`PFCU_OFS_IMR, `PFCU_IRQ_BITS);
    pfc(`PFCU_RSV_DA, 8'hFF, 16'h0003);
    rd(`PFCU_OFS_RXCNT, 32'h0);
    // random vector: only its timers load
    wr(`PFCU_OFS_CTRL, EN);
    r = $urandom;
    v = r[7:0] | 8'h01;
    t = {14'h0, r[9:8]} + 16'h1;
    pfc(`PFCU_RSV_DA, v, t);
    rd(`PFCU_OFS_RXCNT, 32'h1);
    rd(`PFCU_OFS_ISR, 32'h1000);
    check(o_irq, 1'b1);
    check(o_paused, v);
    for (k = 0; k < 8; k = k + 1) rd({3'h2, k[2:0], 2'h0}, v[k] ? t : 16'h0);
    // reload while paused, addressed to the station
    t = {14'h0, r[11:10]} + 16'h1;
    pfc(SA, 8'hFF, t);
    t0 = $time;
    for (k = 0; k < 8; k = k + 1) rd({3'h2, k[2:0], 2'h0}, t);
    wr(`PFCU_OFS_ISR, `PFCU_IRQ_BITS);
    rd(`PFCU_OFS_ISR, 32'h0);
    n = 0;
    while (o_paused !== 8'h00 && n < 6000) begin
      @(posedge i_ref_clk);
      n = n + 1;
    end
    check($time - t0 + 400 > (t - 1) * 8000 && $time - t0 < t * 8000 + 200, 1);
    rd(`PFCU_OFS_ISR, 32'h2000);
    wr(`PFCU_OFS_IMR, 32'h0);
    repeat (2) @(negedge i_ref_clk);
    check(o_irq, 1'b0);
    wr(`PFCU_OFS_IMR, `PFCU_IRQ_BITS);
    wr(`PFCU_OFS_ISR, `PFCU_IRQ_BITS);
    // one frame each with bad address, type, opcode, receive error and FCS, then a classic frame after negotiation
    for (k = 0; k < 5; k = k + 1) begin
      pfcu_link_model_i.send(k == 0 ? 48'h0180C2000002 : `PFCU_RSV_DA,
        k == 1 ? 16'h8809 : `PFCU_CTL_TYPE, k == 2 ? 16'h1001 : `PFCU_OP_PFC,
        8'hFF, 16'h0009, k == 3, k == 4, 34);
      rd(`PFCU_OFS_RXCNT, 32'h2);
    end
    pfcu_link_model_i.send(`PFCU_RSV_DA, `PFCU_CTL_TYPE, `PFCU_OP_CLASSIC, 8'h05, 16'h0, 0, 0, 18);
    rd(`PFCU_OFS_RXCNT, 32'h2);
    // half duplex counts and flags but loads nothing
    wr(`PFCU_OFS_CFG, 32'h0);
    pfc(`PFCU_RSV_DA, 8'hFF, 16'h0002);
    rd(`PFCU_OFS_RXCNT, 32'h3);
    rd(`PFCU_OFS_ISR, 32'h1000);
    check(o_paused, 8'h00);
    wr(`PFCU_OFS_ISR, `PFCU_IRQ_BITS);
    wr(`PFCU_OFS_CFG, FD);
    pfc(`PFCU_RSV_DA, 8'hFF, 16'h0000);
    rd(`PFCU_OFS_ISR, 32'h2000);
    // retry test mode steps once per receive clock
    wr(`PFCU_OFS_CFG, FD | 32'h1000);
    pfc(`PFCU_RSV_DA, 8'h01, 16'h0005);
    repeat (5) @(posedge rck);
    @(negedge i_ref_clk);
    check(o_paused, 8'h00);
    // transmit request held off by a busy transmitter
    wr(`PFCU_OFS_CFG, FD);
    wr(`PFCU_OFS_ISR, `PFCU_IRQ_BITS);
    r = $urandom;
    v = r[7:0];
    t = r[31:16];
    wr(`PFCU_OFS_TXPFC, {t, 8'h00, v});
    i_tx_busy <= 1'b1;
    pfcu_link_model_i.tx_count = 0;
    wr(`PFCU_OFS_CTRL, EN | 32'h0002_0000);
    repeat (100) @(negedge i_ref_clk);
    check(o_tx_en, 1'b0);
    check(o_tx_hold, 1'b1);
    @(posedge i_ref_clk);
    i_tx_busy <= 1'b0;
    txchk(t);
    rd(`PFCU_OFS_ISR, 32'h4000);
    rd(`PFCU_OFS_TXCNT, 32'h1);
    rd(`PFCU_OFS_RXCNT, 32'h5);
    pfcu_link_model_i.tx_count = 0;
    wr(`PFCU_OFS_CTRL, EN | 32'h0000_1000);
    txchk(16'h0);
    // request without transmit enable is dropped
    wr(`PFCU_OFS_CTRL, 32'h0001_0000);
    wr(`PFCU_OFS_CTRL, 32'h0003_0000);
    repeat (50) @(negedge i_ref_clk);
    check(o_tx_hold, 1'b0);
    rd(`PFCU_OFS_TXCNT, 32'h2);
    end_of_test;
  end
endmodule
bind pfcu_pause_unit pfcu_checker pfcu_checker_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_tx_busy(i_tx_busy), .o_irq(o_irq),
  .o_tx_hold(o_tx_hold), .o_tx_en(o_tx_en), .o_tx_data(o_tx_data), .o_paused(o_paused));
